// File: src/pmes_event_status.sv
/*
 * Power management event status and enable registers with the event
 * routing to system control, management mode and wake outputs.
 * Assumes synchronous event inputs and a simple register port whose
 * byte enables select any byte-granular width.
 */
`timescale 1ns/10ps
`include "pmes_cfg.svh"

module pmes_event_status
  import pmes_pkg::*;
#(
  parameter logic [31:0] OVERRIDE_CYCLES = 32'(`PMES_OVERRIDE_CYCLES),
  parameter logic [15:0] IMPL_MASK = `PMES_STS_MASK
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire pmes_access_t access_in,
  input wire pmes_events_t events_in,
  input wire pmes_power_state_t power_state_in,
  input wire logic event_route_select_in,
  input wire logic alarm_s4_wake_allowed_in,
  output logic [31:0] rdata_out,
  output logic system_control_irq_out,
  output logic management_mode_irq_out,
  output logic wake_request_out,
  output logic force_soft_off_out
);

  pmes_state_t s_q;
  pmes_state_t s_d;

  logic [15:0] sts_mask;
  logic [15:0] en_mask;
  logic [15:0] sts_wr;
  logic [15:0] en_wr;
  logic [15:0] en_wdata;
  logic [15:0] set_bits;
  logic sleeping;
  logic pb_edge;
  logic sb_edge;
  logic al_edge;
  logic wake_event;
  logic irq_event;

  // ==========================================================================
  // byte lane decode
  always_comb begin
    sts_mask = IMPL_MASK & `PMES_STS_MASK;
    en_mask = IMPL_MASK & `PMES_EN_MASK;
    sts_wr = 16'h0000;
    en_wr = 16'h0000;
    en_wdata = 16'h0000;
    if (access_in.wr && access_in.addr == `PMES_STS_OFFSET) begin
      sts_wr[7:0] = access_in.byte_en[0] ? access_in.wdata[7:0] : 8'h00;
      sts_wr[15:8] = access_in.byte_en[1] ? access_in.wdata[15:8] : 8'h00;
      en_wr[7:0] = {8{access_in.byte_en[2]}};
      en_wr[15:8] = {8{access_in.byte_en[3]}};
      en_wdata = access_in.wdata[31:16];
    end else if (access_in.wr && access_in.addr == `PMES_EN_OFFSET) begin
      en_wr[7:0] = {8{access_in.byte_en[0]}};
      en_wr[15:8] = {8{access_in.byte_en[1]}};
      en_wdata = access_in.wdata[15:0];
    end
    sts_wr = sts_wr & sts_mask;
    en_wr = en_wr & en_mask;
  end

  // ==========================================================================
  // event detection
  always_comb begin
    sleeping = power_state_in != PMES_WORKING;
    pb_edge = events_in.power_button & ~s_q.power_button;
    sb_edge = events_in.sleep_button & ~s_q.sleep_button;
    al_edge = events_in.alarm_irq & ~s_q.alarm_irq;
    set_bits = 16'h0000;
    set_bits[`PMES_BIT_TIMER] = events_in.counter_msb ^ s_q.counter_msb;
    set_bits[`PMES_BIT_BUS_MASTER] = events_in.bus_master_req;
    set_bits[`PMES_BIT_FW_ATTN] = events_in.fw_attn;
    set_bits[`PMES_BIT_PWR_BTN] = pb_edge;
    set_bits[`PMES_BIT_SLP_BTN] = sb_edge;
    set_bits[`PMES_BIT_ALARM] = al_edge;
    // wake sources while sleeping
    wake_event = sleeping && (pb_edge
      || (sb_edge && s_q.enable[`PMES_BIT_SLP_BTN])
      || (al_edge && s_q.enable[`PMES_BIT_ALARM]
        && power_state_in != PMES_SOFT_OFF
        && (power_state_in != PMES_SLEEP_S4 || alarm_s4_wake_allowed_in))
      || events_in.other_wake);
    set_bits[`PMES_BIT_WAKE] = wake_event;
    set_bits = set_bits & sts_mask;
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.counter_msb = events_in.counter_msb;
    s_d.power_button = events_in.power_button;
    s_d.sleep_button = events_in.sleep_button;
    s_d.alarm_irq = events_in.alarm_irq;
    // set wins over write-one clear
    s_d.status = ((s_q.status & ~sts_wr) | set_bits) & sts_mask;
    s_d.enable = ((s_q.enable & ~en_wr) | (en_wdata & en_wr)) & en_mask;
    // power button override timer
    if (!events_in.power_button) begin
      s_d.hold_count = 32'h0000_0000;
      s_d.override_done = 1'b0;
    end else if (s_q.hold_count < OVERRIDE_CYCLES) begin
      s_d.hold_count = s_q.hold_count + 32'h0000_0001;
    end else if (!s_q.override_done) begin
      s_d.override_done = 1'b1;
      s_d.status[`PMES_BIT_PWR_BTN] = 1'b0;
    end
    s_d.rdata = 32'h0000_0000;
    if (access_in.rd) begin
      case (access_in.addr)
        `PMES_STS_OFFSET: s_d.rdata = {s_q.enable, s_q.status};
        `PMES_EN_OFFSET: s_d.rdata = {16'h0000, s_q.enable};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.status <= `PMES_STS_RESET;
      s_q.enable <= `PMES_EN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // event outputs
  always_comb begin
    irq_event = !sleeping && |(s_q.status & s_q.enable);
    system_control_irq_out = irq_event && event_route_select_in;
    management_mode_irq_out = irq_event && !event_route_select_in;
    wake_request_out = s_q.status[`PMES_BIT_WAKE] && sleeping;
    force_soft_off_out = s_q.override_done;
    rdata_out = s_q.rdata;
  end

endmodule : pmes_event_status

// File: src/pmes_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the power
 * management event status and enable block.
 * Assumes a 40 MHz system clock and a 16-bit status register.
 */
`ifndef PMES_CFG_SVH
`define PMES_CFG_SVH

// ==========================================================================
// register offsets within the event block (bytes)
`define PMES_STS_OFFSET 2'h0
`define PMES_EN_OFFSET 2'h2

// ==========================================================================
// field positions
`define PMES_BIT_TIMER 0
`define PMES_BIT_BUS_MASTER 4
`define PMES_BIT_FW_ATTN 5
`define PMES_BIT_PWR_BTN 8
`define PMES_BIT_SLP_BTN 9
`define PMES_BIT_ALARM 10
`define PMES_BIT_IGNORED 11
`define PMES_BIT_WAKE 15

// ==========================================================================
// reset values and implemented-bit masks
`define PMES_STS_RESET 16'h0000
`define PMES_EN_RESET 16'h0000
`define PMES_STS_MASK 16'h8731
`define PMES_EN_MASK 16'h0721

// ==========================================================================
// power button override time
`define PMES_OVERRIDE_MS 4000
`define PMES_CLK_HZ 40000000
`define PMES_OVERRIDE_CYCLES ((`PMES_OVERRIDE_MS * (`PMES_CLK_HZ / 1000)) + 1)

`endif

// File: src/pmes_pkg.sv
/*
 * Types for the power management event status block.
 * Assumes pmes_cfg.svh holds every number except the power state codes, which are set here.
 */
package pmes_pkg;

  // ==========================================================================
  // system power states
  typedef enum logic [1:0] {
    PMES_WORKING = 2'h0,
    PMES_SLEEP_S1_S3 = 2'h1,
    PMES_SLEEP_S4 = 2'h3,
    PMES_SOFT_OFF = 2'h2
  } pmes_power_state_t;

  // ==========================================================================
  // register port access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } pmes_access_t;

  // ==========================================================================
  // hardware event sources
  typedef struct packed {
    logic counter_msb;
    logic bus_master_req;
    logic fw_attn;
    logic power_button;
    logic sleep_button;
    logic alarm_irq;
    logic other_wake;
  } pmes_events_t;

  // ==========================================================================
  // whole module state
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] enable;
    logic counter_msb;
    logic power_button;
    logic sleep_button;
    logic alarm_irq;
    logic [31:0] hold_count;
    logic override_done;
    logic [31:0] rdata;
  } pmes_state_t;

endpackage : pmes_pkg

// File: verification/pmes_event_status_sva.sv
/* port checker of the event status block.
   assumes default bit masks; bound to the block below */
`timescale 1ns/10ps
module pmes_event_status_sva
  import pmes_pkg::*;
#(
  parameter logic [31:0] OVERRIDE_CYCLES = 32'h14
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire pmes_access_t access_in,
  input wire pmes_events_t events_in,
  input wire pmes_power_state_t power_state_in,
  input wire logic event_route_select_in,
  input wire logic alarm_s4_wake_allowed_in,
  input wire logic [31:0] rdata_out,
  input wire logic system_control_irq_out,
  input wire logic management_mode_irq_out,
  input wire logic wake_request_out,
  input wire logic force_soft_off_out
);
  // ==========================================================================
  // cycles the power button has been held
  logic [31:0] hold_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= events_in.power_button ? hold_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  reserved_zero_a: assert property ((rdata_out & 32'hf8de_78ce) == 32'h0)
    else $error("reserved bit reads one");
  unmapped_zero_a: assert property (access_in.rd && access_in.addr[0] |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  sleep_quiet_a: assert property (power_state_in != PMES_WORKING |->
    !system_control_irq_out && !management_mode_irq_out) else $error("irq while asleep");
  irq_route_a: assert property (!(system_control_irq_out && !event_route_select_in)
    && !(management_mode_irq_out && event_route_select_in)) else $error("irq misrouted");
  irq_hold_a: assert property (system_control_irq_out && !access_in.wr |=>
    system_control_irq_out || !event_route_select_in || power_state_in != PMES_WORKING)
    else $error("irq dropped without clear");
  wake_state_a: assert property (wake_request_out |-> power_state_in != PMES_WORKING)
    else $error("wake while working");
  button_wake_a: assert property ($rose(events_in.power_button) &&
    power_state_in == PMES_SLEEP_S1_S3 |-> ##[0:3] wake_request_out) else $error("no wake");
  bus_flag_a: assert property (events_in.bus_master_req ##2 (access_in.rd &&
    access_in.addr == 2'h0) |=> rdata_out[4]) else $error("bus flag not set");
  attn_flag_a: assert property (events_in.fw_attn ##2 (access_in.rd &&
    access_in.addr == 2'h0) |=> rdata_out[5]) else $error("attention flag not set");
  off_release_a: assert property (!events_in.power_button |=> !force_soft_off_out)
    else $error("off held after release");
  off_time_a: assert property (force_soft_off_out |-> hold_q >= OVERRIDE_CYCLES - 32'h1)
    else $error("off too early");
endmodule : pmes_event_status_sva
bind pmes_event_status pmes_event_status_sva #(.OVERRIDE_CYCLES(OVERRIDE_CYCLES)) i_sva (.*);

// File: verification/pmes_event_status_bench.sv
/* random and corner tests of the event status block.
   assumes the port checker is bound in */
`timescale 1ns/10ps
module pmes_event_status_bench import pmes_pkg::*; ;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  pmes_access_t acc = '0;
  pmes_events_t ev = '0;
  pmes_power_state_t pst = PMES_WORKING;
  logic route = 1'b0;
  logic [31:0] rdata, got, d;
  logic system_control_irq, management_mode_irq, wake, off;
  logic [15:0] en_m = 16'h0;
  logic [3:0] be;
  int fails = 0;
  int tests_run = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  pmes_event_status #(.OVERRIDE_CYCLES(32'h14)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .access_in(acc), .events_in(ev), .power_state_in(pst),
    .event_route_select_in(route), .alarm_s4_wake_allowed_in(1'b0), .rdata_out(rdata),
    .system_control_irq_out(system_control_irq), .management_mode_irq_out(management_mode_irq),
    .wake_request_out(wake), .force_soft_off_out(off));
  task automatic step();
    @(posedge clk_sys_in);
    #2;
  endtask : step
  task automatic wr(input logic [3:0] b, input logic [31:0] v);
    step();
    acc = '{1'b0, 1'b1, 2'h0, b, v};
    step();
    acc.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    step();
    acc.rd = 1'b1;
    acc.addr = a;
    step();
    acc.rd = 1'b0;
    got = rdata;
  endtask : rd
  task automatic pulse(input pmes_events_t e);
    step();
    ev = e;
    step();
    ev = '0;
  endtask : pulse
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic wait_hi(input logic which);
    for (int i = 0; i < 40 && (which ? off : wake) !== 1'b1; i++) begin
      step();
    end
    if ((which ? off : wake) !== 1'b1) begin
      fails++;
      $display("Error %0t: wait ran out", $time);
      stop_test();
    end
  endtask : wait_hi
  // enable lanes 2 and 3 keep only bits 0, 5, 8, 9 and 10
  function automatic logic [15:0] en_next(input logic [15:0] e, input logic [3:0] b,
      input logic [31:0] v);
    en_next = e;
    if (b[2]) en_next[7:0] = v[23:16] & 8'h21;
    if (b[3]) en_next[15:8] = v[31:24] & 8'h07;
  endfunction : en_next
  initial begin
    void'($urandom(25));
    repeat (16) @(posedge clk_sys_in);
    #2;
    rst_n_in = 1'b1;
    // firmware hands over: clear status, then select system interrupt
    wr(4'h3, 32'h0000_ffff);
    route = 1'b1;
    rd(2'h0);
    chk(got, 32'h0);
    wr(4'hc, 32'hffff_ffff);
    en_m = 16'h0721;
    rd(2'h0);
    chk(got, {en_m, 16'h0});
    rd(2'h1);
    chk(got, 32'h0);
    pulse(7'h7e);
    rd(2'h0);
    chk(got, {en_m, 16'h0731});
    repeat (5) step();
    chk(32'(system_control_irq), 32'h1);
    chk(32'(management_mode_irq), 32'h0);
    route = 1'b0;
    step();
    chk(32'({system_control_irq, management_mode_irq}), 32'h1);
    route = 1'b1;
    wr(4'h1, 32'h31);
    rd(2'h0);
    chk(got, {en_m, 16'h0700});
    wr(4'h2, 32'h0700);
    rd(2'h0);
    chk(got, {en_m, 16'h0});
    chk(32'(system_control_irq), 32'h0);
    $display("test sources and clears done");
    for (int k = 0; k < 24; k++) begin
      be = 4'($urandom);
      d = $urandom;
      wr(be, d);
      en_m = en_next(en_m, be, d);
      rd(2'h0);
      chk(got, {en_m, 16'h0});
    end
    $display("test random access done");
    wr(4'hc, 32'h0);
    en_m = 16'h0;
    pst = PMES_SLEEP_S1_S3;
    pulse(7'h04);
    repeat (4) step();
    chk(32'(wake), 32'h0);
    pulse(7'h08);
    wait_hi(1'b0);
    rd(2'h0);
    chk(got, 32'h8300);
    chk(got & 32'hffff_f7ff, 32'h0000_8300);
    chk(32'(system_control_irq), 32'h0);
    pst = PMES_WORKING;
    wr(4'h3, 32'hffff);
    step();
    chk(32'(wake), 32'h0);
    $display("test sleep wake done");
    ev.power_button = 1'b1;
    repeat (10) step();
    chk(32'(off), 32'h0);
    wait_hi(1'b1);
    rd(2'h0);
    chk(got, 32'h0);
    chk(got & 32'hffff_feff, 32'h0);
    ev.power_button = 1'b0;
    repeat (2) step();
    chk(32'(off), 32'h0);
    $display("test override done");
    stop_test();
  end
endmodule : pmes_event_status_bench
